// ==== rid_alu.v ====
// Arithmetic core for add and subtract with carry and digit carry
`timescale 1ns/1ps
module rid_alu
(
  input wire [7:0] a,
  input wire [7:0] b,
  input wire sub,
  output wire [7:0] res,
  output wire carry,
  output wire dcarry
);
  // Subtract as a + ~b + 1, carry meaning no borrow
  wire [7:0] bb;
  wire [4:0] lo;
  wire [8:0] full;
  assign bb = sub ? ~b : b;
  assign lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
  assign full = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
  assign res = full[7:0];
  assign carry = full[8];
  assign dcarry = lo[4];
endmodule

// ==== rid_consts.vh ====
// Constants for the instruction decoder and execution control
`ifndef RID_CONSTS_VH
`define RID_CONSTS_VH
`define RID_WORD_W 14
`define RID_ADDR_W 7
`define RID_PC_W 13
`define RID_TGT_W 11
`define RID_PHASES 4
`define RID_PH_DECODE 2'h0
`define RID_PH_READ 2'h1
`define RID_PH_PROCESS 2'h2
`define RID_PH_WRITE 2'h3
`define RID_OP_MOVE_ACC 4'h0
`define RID_OP_CLEAR 4'h1
`define RID_OP_SUB 4'h2
`define RID_OP_DEC 4'h3
`define RID_OP_OR 4'h4
`define RID_OP_AND 4'h5
`define RID_OP_XOR 4'h6
`define RID_OP_ADD 4'h7
`define RID_OP_MOVF 4'h8
`define RID_OP_COMP 4'h9
`define RID_OP_INC 4'ha
`define RID_OP_DECSZ 4'hb
`define RID_OP_RRC 4'hc
`define RID_OP_RLC 4'hd
`define RID_OP_SWAP 4'he
`define RID_OP_INCSZ 4'hf
`define RID_W_RETURN 14'h0008
`define RID_W_INTERRUPT_RETURN 14'h0009
`define RID_W_SLEEP 14'h0063
`define RID_W_WATCHDOG_CLEAR_OP 14'h0064
`define RID_TIMER_ZERO_COUNT_ADDR 7'h01
`define RID_STATUS_RESET 5'h18
`endif

// ==== rid_core.v ====
// Instruction decoder and execution control for the 14-bit instruction set
// What this block does
// - Byte OR, XOR, AND combine acc and file, complement inverts file, zero only.
// - Literal add and literal minus acc update carry, digit carry, zero.
// - Literal AND, OR, XOR go into the acc and touch only zero.
// - Rotate left or right through carry changes only carry.
// - Decrement or increment with skip on zero leave flags unchanged.
// - Bit ops clear, set, or skip on clear or set of a chosen bit.
// - A taken skip or a change of PC costs a second, idle cycle.
// - Return, interrupt return and literal return take two cycles.
// - Standby and watchdog clear update time-out and power-down bits.
// - Read-modify-write of a port register reads the pin levels.
// - Writing the timer count register clears an assigned prescaler.
// - Destination bit zero writes the acc, one writes the file.
// - Each instruction cycle spans decode, read, process, write.
`timescale 1ns/1ps
`include "rid_consts.vh"
module rid_core
#(
  parameter PORT_A_ADDR = 7'h05,
  parameter PORT_B_ADDR = 7'h06
)
(
  input wire sys_clk,
  input wire rstn,
  input wire clk_en,
  input wire [13:0] instr,
  output reg [12:0] pc,
  output reg [6:0] file_addr,
  input wire [7:0] file_rdata,
  input wire [7:0] pin_rdata,
  output reg file_we,
  output reg [7:0] file_wdata,
  input wire [12:0] stack_top,
  output reg stack_push,
  output reg stack_pop,
  output reg [12:0] push_value,
  input wire [4:0] pc_high_latch,
  input wire prescaler_on_timer,
  output reg prescaler_clear,
  output reg watchdog_clear,
  output reg standby_enter,
  output reg int_enable_set,
  output reg [7:0] acc,
  output reg carry_flag,
  output reg digit_carry_flag,
  output reg zero_flag,
  output reg timeout_flag,
  output reg powerdown_flag
);
  ////////////////////////////////////////////////////////////////
  // Phase counter and latched instruction
  reg [1:0] phase;
  reg [13:0] ir;
  reg flush;
  reg [7:0] opnd;
  reg [7:0] result;
  reg res_we_file;
  reg res_we_acc;
  reg skip_take;
  reg pc_load;
  reg [12:0] pc_target;

  function is_port;
    input [6:0] a;
    begin
      is_port = (a == PORT_A_ADDR) || (a == PORT_B_ADDR);
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Decode fields
  wire [1:0] grp;
  wire [3:0] op;
  wire dst;
  wire [2:0] bit_idx;
  wire [7:0] lit;
  wire [7:0] bmask;
  assign grp = ir[13:12];
  assign op = ir[11:8];
  assign dst = ir[7];
  assign bit_idx = ir[9:7];
  assign lit = ir[7:0];
  assign bmask = 8'h01 << bit_idx;

  ////////////////////////////////////////////////////////////////
  // Adder shared by file and literal arithmetic
  reg [7:0] alu_a;
  reg [7:0] alu_b;
  reg alu_sub;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  rid_alu u_alu
  (
    .a(alu_a),
    .b(alu_b),
    .sub(alu_sub),
    .res(alu_res),
    .carry(alu_c),
    .dcarry(alu_dc)
  );

  ////////////////////////////////////////////////////////////////
  // Execute decision, combinational, taken up at the end of the write phase
  reg next_c;
  reg next_dc;
  reg next_z;
  reg upd_z;
  always @*
  begin
    opnd = is_port(ir[6:0]) ? pin_rdata : file_rdata;
    result = 8'h00;
    res_we_file = 1'b0;
    res_we_acc = 1'b0;
    skip_take = 1'b0;
    pc_load = 1'b0;
    pc_target = pc;
    next_c = carry_flag;
    next_dc = digit_carry_flag;
    upd_z = 1'b0;
    alu_a = opnd;
    alu_b = acc;
    alu_sub = 1'b0;
    case (grp)
      2'b00:
      begin
        res_we_file = dst;
        res_we_acc = ~dst;
        upd_z = 1'b1;
        case (op)
          `RID_OP_MOVE_ACC:
          begin
            upd_z = 1'b0;
            res_we_acc = 1'b0;
            res_we_file = dst;
            result = acc;
          end
          `RID_OP_CLEAR: result = 8'h00;
          `RID_OP_SUB, `RID_OP_ADD:
          begin
            alu_sub = ~op[2];
            result = alu_res;
            next_c = alu_c;
            next_dc = alu_dc;
          end
          `RID_OP_DEC: result = opnd - 8'h01;
          `RID_OP_OR: result = acc | opnd;
          `RID_OP_AND: result = acc & opnd;
          `RID_OP_XOR: result = acc ^ opnd;
          `RID_OP_MOVF: result = opnd;
          `RID_OP_COMP: result = ~opnd;
          `RID_OP_INC: result = opnd + 8'h01;
          `RID_OP_DECSZ:
          begin
            upd_z = 1'b0;
            result = opnd - 8'h01;
            skip_take = (result == 8'h00);
          end
          `RID_OP_INCSZ:
          begin
            upd_z = 1'b0;
            result = opnd + 8'h01;
            skip_take = (result == 8'h00);
          end
          `RID_OP_RRC:
          begin
            upd_z = 1'b0;
            result = {carry_flag, opnd[7:1]};
            next_c = opnd[0];
          end
          `RID_OP_RLC:
          begin
            upd_z = 1'b0;
            result = {opnd[6:0], carry_flag};
            next_c = opnd[7];
          end
          `RID_OP_SWAP:
          begin
            upd_z = 1'b0;
            result = {opnd[3:0], opnd[7:4]};
          end
          default: result = opnd;
        endcase
        if (ir == `RID_W_RETURN || ir == `RID_W_INTERRUPT_RETURN)
        begin
          pc_load = 1'b1;
          pc_target = stack_top;
        end
      end
      2'b01:
      begin
        case (ir[11:10])
          2'b00:
          begin
            result = opnd & ~bmask;
            res_we_file = 1'b1;
          end
          2'b01:
          begin
            result = opnd | bmask;
            res_we_file = 1'b1;
          end
          2'b10: skip_take = ~|(opnd & bmask);
          default: skip_take = |(opnd & bmask);
        endcase
      end
      2'b10:
      begin
        pc_load = 1'b1;
        pc_target = {pc_high_latch[4:3], ir[10:0]};
      end
      default:
      begin
        res_we_acc = 1'b1;
        alu_a = lit;
        upd_z = 1'b1;
        case (ir[11:8])
          4'h8: result = acc | lit;
          4'h9: result = acc & lit;
          4'ha: result = acc ^ lit;
          4'hc, 4'hd, 4'he, 4'hf:
          begin
            alu_sub = ~ir[9];
            result = alu_res;
            next_c = alu_c;
            next_dc = alu_dc;
          end
          4'h4, 4'h5, 4'h6, 4'h7:
          begin
            upd_z = 1'b0;
            result = lit;
            pc_load = 1'b1;
            pc_target = stack_top;
          end
          default:
          begin
            upd_z = 1'b0;
            result = lit;
          end
        endcase
      end
    endcase
    next_z = upd_z ? (result == 8'h00) : zero_flag;
  end

  ////////////////////////////////////////////////////////////////
  // Four-phase sequencer and state update
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      phase <= `RID_PH_DECODE;
      ir <= 14'h0000;
      flush <= 1'b1;
      pc <= 13'h0000;
      file_addr <= 7'h00;
      file_we <= 1'b0;
      file_wdata <= 8'h00;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      push_value <= 13'h0000;
      prescaler_clear <= 1'b0;
      watchdog_clear <= 1'b0;
      standby_enter <= 1'b0;
      int_enable_set <= 1'b0;
      acc <= 8'h00;
      {timeout_flag, powerdown_flag, carry_flag, digit_carry_flag,
        zero_flag} <= `RID_STATUS_RESET;
    end
    else if (clk_en)
    begin
      phase <= phase + 2'h1;
      file_we <= 1'b0;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      prescaler_clear <= 1'b0;
      watchdog_clear <= 1'b0;
      standby_enter <= 1'b0;
      int_enable_set <= 1'b0;
      case (phase)
        `RID_PH_DECODE:
        begin
          ir <= instr;
          file_addr <= instr[6:0];
        end
        `RID_PH_READ, `RID_PH_PROCESS: ;
        default:
        begin
          pc <= pc + 13'h0001;
          flush <= 1'b0;
          if (!flush)
          begin
            carry_flag <= next_c;
            digit_carry_flag <= next_dc;
            zero_flag <= next_z;
            if (res_we_acc)
              acc <= result;
            if (res_we_file)
            begin
              file_we <= 1'b1;
              file_wdata <= result;
              if (ir[6:0] == `RID_TIMER_ZERO_COUNT_ADDR && prescaler_on_timer)
                prescaler_clear <= 1'b1;
            end
            if (skip_take || pc_load)
              flush <= 1'b1;
            if (pc_load)
              pc <= pc_target;
            if (grp == 2'b10 && !ir[11])
            begin
              stack_push <= 1'b1;
              push_value <= pc;
            end
            if (ir == `RID_W_RETURN || ir == `RID_W_INTERRUPT_RETURN
              || ir[13:10] == 4'hd)
              stack_pop <= 1'b1;
            if (ir == `RID_W_INTERRUPT_RETURN)
              int_enable_set <= 1'b1;
            if (ir == `RID_W_SLEEP)
            begin
              timeout_flag <= 1'b1;
              powerdown_flag <= 1'b0;
              watchdog_clear <= 1'b1;
              standby_enter <= 1'b1;
            end
            if (ir == `RID_W_WATCHDOG_CLEAR_OP)
            begin
              timeout_flag <= 1'b1;
              powerdown_flag <= 1'b1;
              watchdog_clear <= 1'b1;
            end
          end
        end
      endcase
    end
  end
endmodule

// ==== rid_core_asserts.sv ====
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
module rid_core_asserts
(
  input wire sys_clk,
  input wire rstn,
  input wire [12:0] pc,
  input wire [6:0] file_addr,
  input wire file_we,
  input wire stack_push,
  input wire stack_pop,
  input wire prescaler_on_timer,
  input wire prescaler_clear,
  input wire watchdog_clear,
  input wire standby_enter,
  input wire int_enable_set,
  input wire [7:0] acc,
  input wire zero_flag,
  input wire timeout_flag,
  input wire powerdown_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_write_spacing: assert property (file_we |=> !file_we [*3])
    else $error("write strobe too close");
  a_pc_step: assert property ($changed(pc) |=> $stable(pc) [*3])
    else $error("pc moved twice in one cycle");
  a_push_pulse: assert property (stack_push |=> !stack_push)
    else $error("push longer than one cycle");
  a_pop_alone: assert property (stack_pop |-> !stack_push)
    else $error("pop and push together");
  a_ret_irq: assert property (int_enable_set |-> stack_pop)
    else $error("interrupt return without pop");
  a_prescale_clear: assert property
    ((file_we && file_addr == 7'h01 && prescaler_on_timer)
     |-> prescaler_clear)
    else $error("timer write kept prescaler");
  a_standby_flags: assert property
    (standby_enter |-> ##[0:2] (timeout_flag && !powerdown_flag))
    else $error("standby flags wrong");
  a_wdt_flags: assert property
    ((watchdog_clear && !standby_enter)
     |-> ##[0:2] (timeout_flag && powerdown_flag))
    else $error("watchdog clear flags wrong");
  a_reset_state: assert property
    ($rose(rstn) |-> timeout_flag && powerdown_flag && !zero_flag
     && acc == 8'h00 && pc == 13'h0000)
    else $error("state after reset wrong");
endmodule

// ==== rid_core_tb.sv ====
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    check_count = check_count + 1; \
    if ((g) !== (e)) \
    begin \
      err_total = err_total + 1; \
      $display("unexpected %s exp %h got %h", n, e, g); \
    end \
  end
module rid_core_tb;
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  wire [13:0] instr;
  wire [12:0] pc;
  wire [6:0] file_addr;
  wire [7:0] file_rdata;
  wire [7:0] file_wdata;
  wire [7:0] acc;
  wire file_we;
  wire carry_flag;
  wire digit_carry_flag;
  wire zero_flag;
  wire timeout_flag;
  wire powerdown_flag;
  wire [4:0] flg;
  reg clk_en = 1'b1;
  wire stack_push;
  wire stack_pop;
  wire int_enable_set;
  wire watchdog_clear;
  wire standby_enter;
  wire prescaler_clear;
  wire [12:0] push_value;
  reg [5:0] seen;
  integer freeze = 0;
  integer err_total = 0;
  integer check_count = 0;
  integer i;
  // Instr, start file value, acc, file value, flags, skip
  reg [51:0] rows [0:29] = '{
    52'h0420c2d7c2180, 52'h05a0c21702180, 52'h0620c2d5c2180,
    52'h0920c23dc2180, 52'h0906c2f0c2180, 52'h3ee9c200c21f0,
    52'h3c10c2f9c2180, 52'h395fc217c2180, 52'h3828c23fc2180,
    52'h3a17c200c21c0, 52'h0d20c284c2190, 52'h0ca0c31761190,
    52'h01a0c217001c0, 52'h0100c200c21c0, 52'h00a0c21717180,
    52'h0ba0011700181, 52'h0fa0ff1700181, 52'h0fa0101711180,
    52'h1ba0421742181, 52'h1fa0421742180, 52'h13a0c71747180,
    52'h1420021703180, 52'h3434c234c2581, 52'h0008c217c2581,
    52'h0009c217c2781, 52'h2803c217c2181, 52'h2003c217c2981,
    52'h0063c217c210c, 52'h0064c217c2188, 52'h0181c217c21c2
  };
  assign flg = {timeout_flag, powerdown_flag, zero_flag, digit_carry_flag,
    carry_flag};
  always #10 sys_clk = ~sys_clk;
  rid_core i_rid_core (.sys_clk, .rstn, .clk_en, .instr, .pc,
    .file_addr, .file_rdata, .pin_rdata(8'h0f), .file_we, .file_wdata,
    .stack_top(13'h0003), .stack_push, .stack_pop, .push_value,
    .pc_high_latch(5'h00), .prescaler_on_timer(1'b1), .prescaler_clear,
    .watchdog_clear, .standby_enter, .int_enable_set, .acc,
    .carry_flag, .digit_carry_flag, .zero_flag, .timeout_flag,
    .powerdown_flag);
  rid_mem_model i_rid_mem_model (.sys_clk, .pc, .file_addr, .file_we,
    .file_wdata, .instr, .file_rdata);
  // Pulses seen since the last reset
  always @(posedge sys_clk)
  begin
    if (!rstn)
      seen <= 6'h00;
    else
      seen <= seen | {stack_push, stack_pop, int_enable_set, watchdog_clear,
        standby_enter, prescaler_clear};
  end
  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Load acc, run one instruction, then a marker write
  task run_row;
    input [51:0] r;
    begin
      @(posedge sys_clk);
      rstn <= 1'b0;
      i_rid_mem_model.prog[0] = 14'h3017;
      i_rid_mem_model.prog[1] = r[49:36];
      i_rid_mem_model.prog[2] = 14'h1421;
      i_rid_mem_model.regs[32] = r[35:28];
      i_rid_mem_model.regs[33] = 8'h00;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (10) @(posedge sys_clk);
      if (freeze != 0)
      begin
        clk_en <= 1'b0;
        repeat (freeze) @(posedge sys_clk);
        clk_en <= 1'b1;
        #1;
        `CHK("frozen acc", 8'h17, acc)
        `CHK("frozen pc", 13'h0002, pc)
      end
      repeat (38) @(posedge sys_clk);
      #1;
      `CHK("acc", r[27:20], acc)
      `CHK("file", r[19:12], i_rid_mem_model.regs[32])
      `CHK("flags", r[8:4], flg)
      `CHK("skip", {7'h00, ~r[0]}, i_rid_mem_model.regs[33])
      `CHK("pulses", {r[11:9], r[3:1]}, seen)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (i = 0; i < 16; i = i + 1)
      i_rid_mem_model.prog[i] = 14'h0000;
    for (i = 0; i < 30; i = i + 1)
      run_row(rows[i]);
    // Freeze mid-instruction on a call, then check the return address
    freeze = 40;
    run_row(rows[26]);
    `CHK("return address", 13'h0002, push_value)
    // Reset in mid-run after the call program, whose flags stay at the reset value
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("reset acc", 8'h00, acc)
    `CHK("reset flags", 5'h18, flg)
    `CHK("reset pc", 13'h0000, pc)
    complete_run;
  end
  initial
  begin
    #200000;
    err_total = err_total + 1;
    complete_run;
  end
endmodule
bind rid_core rid_core_asserts i_rid_core_asserts (.sys_clk, .rstn, .pc,
  .file_addr, .file_we, .stack_push, .stack_pop, .prescaler_on_timer,
  .prescaler_clear, .watchdog_clear, .standby_enter, .int_enable_set, .acc,
  .zero_flag, .timeout_flag, .powerdown_flag);

// ==== rid_mem_model.sv ====
// Program memory and file registers facing the decoder
`timescale 1ns/1ps
module rid_mem_model
(
  input wire sys_clk,
  input wire [12:0] pc,
  input wire [6:0] file_addr,
  input wire file_we,
  input wire [7:0] file_wdata,
  output reg [13:0] instr,
  output wire [7:0] file_rdata
);
  reg [13:0] prog [0:15];
  reg [7:0] regs [0:127];
  initial instr = 14'h0000;
  // Fetch one cycle behind the counter
  always @(posedge sys_clk)
  begin
    instr <= (pc < 13'h0010) ? prog[pc[3:0]] : 14'h0000;
    if (file_we)
      regs[file_addr] <= file_wdata;
  end
  assign file_rdata = regs[file_addr];
endmodule
